// [common/adccal_defines.svh]
// Purpose: Offsets, field positions, reset values and timing counts for the calibration control.
// Assumes: Register port with 10-bit addresses and 8-bit data; clock at 10 MHz.
// Notes: Addresses 0x00, 0x07, 0x1E and 0xC0 follow the converter's register map.
`ifndef ADCCAL_DEFINES_SVH
`define ADCCAL_DEFINES_SVH

`define ADCCAL_AW 10
`define ADCCAL_DW 8

`define ADCCAL_ADDR_CTRL 10'h000
`define ADCCAL_ADDR_DLY_LO 10'h007
`define ADCCAL_ADDR_DLY_HI 10'h01E
`define ADCCAL_ADDR_STAT 10'h0C0

`define ADCCAL_CTRL_SOFT_RST_BIT 0
`define ADCCAL_CTRL_STANDBY_BIT 1
`define ADCCAL_CTRL_SHUTDOWN_BIT 2

`define ADCCAL_CTRL_RST_VAL 8'h01
`define ADCCAL_DLY_LO_RST_VAL 8'h00
`define ADCCAL_DLY_HI_RST_VAL 8'h00

`define ADCCAL_STAT_CAL_DONE_BIT 0
`define ADCCAL_STAT_BUSY_BIT 1
`define ADCCAL_STAT_SYNC_MASTER_BIT 2

// Cycle counts given as powers of two.
`define ADCCAL_PCAL_LOG2 27
`define ADCCAL_BGCAL_LOG2 30
`define ADCCAL_POR_WAIT_LOG2 20
// Length of the sync pulse a master drives.
`define ADCCAL_SYNC_PULSE_CYC 4

`endif

// [common/adccal_pkg.sv]
// Purpose: Types shared by the calibration control design.
// Assumes: Constants come from adccal_defines.svh.
// Notes: State codes are binary and written out.
package adccal_pkg;

    typedef enum logic [2:0]
    {
        ADCCAL_ST_POR_WAIT = 3'h0,
        ADCCAL_ST_SYNC = 3'h1,
        ADCCAL_ST_CAL = 3'h2,
        ADCCAL_ST_RUN = 3'h3,
        ADCCAL_ST_SOFT_RST = 3'h4
    } adccal_state_e;

    typedef logic [7:0] adccal_byte_t;

endpackage

// [logic/adccal_counter.sv]
// Purpose: Free counter with a terminal pulse at a programmable length of limit cycles.
// Assumes: Length is fixed while counting; clear restarts from zero.
// Notes: Wide enough for the background period.
`timescale 1ns/100ps

module adccal_counter
    import adccal_pkg::*;
#(
    parameter int W = 31
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic clear,
    input wire logic run,
    input wire logic [W-1:0] limit,
    // Status
    output logic done
);

    logic [W-1:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            done <= 1'b0;
        end
        else if (clear || !run)
        begin
            cnt_q <= '0;
            done <= 1'b0;
        end
        else
        begin
            done <= cnt_q == limit - W'(1);
            cnt_q <= (cnt_q == limit - W'(1)) ? '0 : cnt_q + W'(1);
        end
    end

endmodule

// [logic/adccal_ctrl.sv]
// Purpose: Calibration, reset, power mode and multi-device sync control of a converter.
// Assumes: Register port with one-cycle strobes; reset pin and sync pin synchronous to clk.
// Notes: Long counts are parameters so a simulation can shorten them.
//        The start delay is scaled by DLY_UNIT_CYC; the product must fit in 31 bits.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "adccal_defines.svh"

module adccal_ctrl
    import adccal_pkg::*;
#(
    parameter int PCAL_CYC = 2 ** `ADCCAL_PCAL_LOG2,
    parameter int BGCAL_CYC = 2 ** `ADCCAL_BGCAL_LOG2,
    parameter int POR_WAIT_CYC = 2 ** `ADCCAL_POR_WAIT_LOG2,
    parameter int DLY_UNIT_CYC = 256
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Hardware reset pin, active low, recalibration on its rising edge
    input wire logic hw_reset_n,
    // Role strap and sync pin
    input wire logic follower_strap,
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_oe_n,
    // Register port
    input wire logic [`ADCCAL_AW-1:0] reg_addr,
    input wire logic [`ADCCAL_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`ADCCAL_DW-1:0] reg_rdata,
    // Status and power controls
    output logic cal_done,
    output logic data_valid,
    output logic bg_cal_active,
    output logic cal_regs_init,
    output logic core_clk_en,
    output logic ref_en,
    output logic analog_en
);

    localparam int CW = 31;

    logic rs1_q;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    adccal_state_e state_q;
    adccal_byte_t ctrl_q;
    adccal_byte_t dly_lo_q;
    adccal_byte_t dly_hi_q;
    logic hw_q;
    logic sync_seen;
    logic cnt_done;
    logic bg_done;
    logic [CW-1:0] limit;
    logic [CW-1:0] dly_cnt_q;
    logic cnt_clr;
    logic hw_rise;
    logic soft_bit;
    logic soft_rise;
    logic soft_prev_q;
    logic wr_ctrl;
    logic cnt_q_armed;
    logic load_defaults;

    function automatic logic hit(input logic [`ADCCAL_AW-1:0] a, input logic [`ADCCAL_AW-1:0] b);
        hit = a == b;
    endfunction

    // True while either kind of reset holds the calibration logic at its defaults.
    function automatic logic in_reset(input adccal_state_e s, input logic pin_n);
        in_reset = s == ADCCAL_ST_SOFT_RST || !pin_n;
    endfunction

    assign soft_bit = ctrl_q[`ADCCAL_CTRL_SOFT_RST_BIT];
    assign wr_ctrl = reg_wr && hit(reg_addr, `ADCCAL_ADDR_CTRL);

    // Pin edge detection; the pin is taken as synchronous. Both history flops reset to the
    // idle level, so no false rising edge follows reset.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            hw_q <= 1'b1;
        else
            hw_q <= hw_reset_n;
    end

    // Soft reset bit history for the exit edge.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            soft_prev_q <= 1'b1;
        else
            soft_prev_q <= soft_bit;
    end
    assign hw_rise = hw_reset_n && !hw_q;
    assign soft_rise = soft_bit && !soft_prev_q;

    // Defaults return while the reset pin is held low and at the end of the power-on wait.
    assign load_defaults = !hw_reset_n || (state_q == ADCCAL_ST_POR_WAIT && cnt_done);

    // Control register; writes during a held reset pin are ignored.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_q <= `ADCCAL_CTRL_RST_VAL;
        else if (load_defaults)
            ctrl_q <= `ADCCAL_CTRL_RST_VAL;
        else if (wr_ctrl)
            ctrl_q <= reg_wdata;
    end

    // Calibration start delay registers.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dly_lo_q <= `ADCCAL_DLY_LO_RST_VAL;
            dly_hi_q <= `ADCCAL_DLY_HI_RST_VAL;
        end
        else if (load_defaults)
        begin
            dly_lo_q <= `ADCCAL_DLY_LO_RST_VAL;
            dly_hi_q <= `ADCCAL_DLY_HI_RST_VAL;
        end
        else if (reg_wr)
        begin
            if (hit(reg_addr, `ADCCAL_ADDR_DLY_LO))
                dly_lo_q <= reg_wdata;
            if (hit(reg_addr, `ADCCAL_ADDR_DLY_HI))
                dly_hi_q <= reg_wdata;
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (!reg_rd)
            reg_rdata <= 8'h00;
        else if (hit(reg_addr, `ADCCAL_ADDR_CTRL))
            reg_rdata <= ctrl_q;
        else if (hit(reg_addr, `ADCCAL_ADDR_DLY_LO))
            reg_rdata <= dly_lo_q;
        else if (hit(reg_addr, `ADCCAL_ADDR_DLY_HI))
            reg_rdata <= dly_hi_q;
        else if (hit(reg_addr, `ADCCAL_ADDR_STAT))
            reg_rdata <= {5'h00, !follower_strap, bg_cal_active, cal_done};
        else
            reg_rdata <= 8'h00;
    end

    // Start delay before a calibration, in units of DLY_UNIT_CYC. It counts down only after
    // the sync event and stops at zero, so a zero delay cannot wrap to a huge wait.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            dly_cnt_q <= '0;
        else if (state_q != ADCCAL_ST_SYNC)
            dly_cnt_q <= CW'({dly_hi_q, dly_lo_q}) * CW'(DLY_UNIT_CYC);
        else if ((sync_seen || cnt_q_armed) && dly_cnt_q != '0)
            dly_cnt_q <= dly_cnt_q - CW'(1);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q_armed <= 1'b0;
        else if (state_q != ADCCAL_ST_SYNC)
            cnt_q_armed <= 1'b0;
        else if (sync_seen)
            cnt_q_armed <= 1'b1;
    end

    // Main sequence. A held reset pin wins over everything, then its rising edge; a cleared soft bit comes next,
    // except in the power-on wait, which must finish loading the defaults first.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ADCCAL_ST_POR_WAIT;
        else if (!hw_reset_n)
            state_q <= ADCCAL_ST_POR_WAIT;
        else if (hw_rise)
            state_q <= ADCCAL_ST_SYNC;
        else if (!soft_bit && state_q != ADCCAL_ST_POR_WAIT)
            state_q <= ADCCAL_ST_SOFT_RST;
        else
        begin
            unique case (state_q)
                ADCCAL_ST_POR_WAIT:
                    if (cnt_done)
                        state_q <= ADCCAL_ST_SYNC;
                ADCCAL_ST_SYNC:
                    if (cnt_q_armed && dly_cnt_q == '0)
                        state_q <= ADCCAL_ST_CAL;
                ADCCAL_ST_CAL:
                    if (cnt_done)
                        state_q <= ADCCAL_ST_RUN;
                ADCCAL_ST_RUN:
                    state_q <= ADCCAL_ST_RUN;
                ADCCAL_ST_SOFT_RST:
                    if (soft_rise)
                        state_q <= ADCCAL_ST_SYNC;
                default:
                    state_q <= ADCCAL_ST_POR_WAIT;
            endcase
        end
    end

    // The pin-held phase waits only for its rising edge, never for the count.
    always_comb
    begin
        limit = CW'(PCAL_CYC);
        if (state_q == ADCCAL_ST_POR_WAIT)
            limit = hw_reset_n ? CW'(POR_WAIT_CYC) : CW'(PCAL_CYC);
    end
    assign cnt_clr = hw_rise || !hw_reset_n || (state_q == ADCCAL_ST_SYNC);

    adccal_counter #(.W(CW)) u_phase_cnt
    (
        .clk(sys_clk),
        .rst_n(rst_n),
        .clear(cnt_clr),
        .run(state_q == ADCCAL_ST_POR_WAIT || state_q == ADCCAL_ST_CAL),
        .limit(limit),
        .done(cnt_done)
    );

    adccal_counter #(.W(CW)) u_bg_cnt
    (
        .clk(sys_clk),
        .rst_n(rst_n),
        .clear(1'b0),
        .run(state_q == ADCCAL_ST_RUN && !ctrl_q[`ADCCAL_CTRL_STANDBY_BIT]),
        .limit(CW'(BGCAL_CYC)),
        .done(bg_done)
    );

    adccal_sync_pin u_sync
    (
        .clk(sys_clk),
        .rst_n(rst_n),
        .is_follower(follower_strap),
        .fire(state_q == ADCCAL_ST_SYNC && !cnt_q_armed && !sync_seen),
        .sync_in(sync_in),
        .sync_out(sync_out),
        .sync_oe_n(sync_oe_n),
        .sync_seen(sync_seen)
    );

    // Calibration status and data gating.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_done <= 1'b0;
            data_valid <= 1'b0;
        end
        else
        begin
            cal_done <= state_q == ADCCAL_ST_RUN;
            data_valid <= state_q == ADCCAL_ST_RUN && !ctrl_q[`ADCCAL_CTRL_SHUTDOWN_BIT]
                && !ctrl_q[`ADCCAL_CTRL_STANDBY_BIT];
        end
    end

    // Background marker; it toggles so a slow reader still sees every period.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            bg_cal_active <= 1'b0;
        else if (state_q != ADCCAL_ST_RUN)
            bg_cal_active <= 1'b0;
        else if (bg_done)
            bg_cal_active <= !bg_cal_active;
    end

    // Calibration registers are held at their defaults during either reset.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cal_regs_init <= 1'b1;
        else
            cal_regs_init <= in_reset(state_q, hw_reset_n);
    end

    // Power enables; the reference follows only the shutdown bit and is not gated by a reset.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_clk_en <= 1'b0;
            ref_en <= 1'b1;
            analog_en <= 1'b0;
        end
        else
        begin
            core_clk_en <= !in_reset(state_q, hw_reset_n)
                && !ctrl_q[`ADCCAL_CTRL_SHUTDOWN_BIT];
            ref_en <= !ctrl_q[`ADCCAL_CTRL_SHUTDOWN_BIT];
            analog_en <= !ctrl_q[`ADCCAL_CTRL_SHUTDOWN_BIT]
                && !ctrl_q[`ADCCAL_CTRL_STANDBY_BIT];
        end
    end

endmodule

// [logic/adccal_sync_pin.sv]
// Purpose: Drives or receives the shared sync pin depending on the role strap.
// Assumes: Role strap is stable after reset; the pin input is synchronous to the clock.
// Notes: Output enable is low while this end drives the pin.
`timescale 1ns/100ps
`include "adccal_defines.svh"

module adccal_sync_pin
    import adccal_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic is_follower,
    input wire logic fire,
    // Pin
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_oe_n,
    // Result
    output logic sync_seen
);

    localparam int PW = `ADCCAL_SYNC_PULSE_CYC;

    logic [2:0] cnt_q;
    logic in_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= 3'h0;
        // Fire may stay high for the whole sync phase; only an idle counter takes it.
        else if (fire && !is_follower && cnt_q == 3'h0)
            cnt_q <= 3'(PW);
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_out <= 1'b0;
            sync_oe_n <= 1'b1;
            in_q <= 1'b0;
        end
        else
        begin
            sync_out <= !is_follower && (cnt_q != 3'h0);
            sync_oe_n <= is_follower;
            in_q <= sync_in;
        end
    end

    // A master counts its own pulse end; a follower waits for the falling edge of the pin.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sync_seen <= 1'b0;
        else if (is_follower)
            sync_seen <= in_q && !sync_in;
        else
            sync_seen <= cnt_q == 3'h1;
    end

endmodule

// [verification/adccal_ctrl_properties.sv]
// Purpose: Port-level checks on the calibration control.
// Assumes: Shortened calibration count handed in through the bind.
// Notes: Windows of 1 to 3 cycles absorb the port registers.
`timescale 1ns/100ps
`include "adccal_defines.svh"

module adccal_ctrl_properties
    import adccal_pkg::*;
#(
    parameter int PCAL_CYC = 64
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hw_reset_n,
    // Sync
    input wire logic follower_strap,
    input wire logic sync_out,
    input wire logic sync_oe_n,
    // Register port
    input wire logic [`ADCCAL_AW-1:0] reg_addr,
    input wire logic [`ADCCAL_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`ADCCAL_DW-1:0] reg_rdata,
    // Status and power
    input wire logic cal_done,
    input wire logic data_valid,
    input wire logic cal_regs_init,
    input wire logic core_clk_en,
    input wire logic ref_en,
    input wire logic analog_en
);
    logic [31:0] low_cnt_q;
    logic ctrl_wr;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // Counts how long the status stays low, so a short calibration is caught.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            low_cnt_q <= 32'h0;
        else if (cal_done)
            low_cnt_q <= 32'h0;
        else
            low_cnt_q <= low_cnt_q + 32'h1;
    end

    assign ctrl_wr = reg_wr && hw_reset_n && reg_addr == `ADCCAL_ADDR_CTRL;

    sequence s_soft_enter;
        ctrl_wr && !reg_wdata[0];
    endsequence
    sequence s_stat_rd;
        reg_rd && reg_addr == `ADCCAL_ADDR_STAT;
    endsequence

    property p_cal_len;
        $rose(cal_done) |-> low_cnt_q >= PCAL_CYC;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration too short");
    property p_soft_hold;
        s_soft_enter |-> ##[1:3] (cal_regs_init && !cal_done);
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("soft reset not held");
    property p_hw_quiet;
        !hw_reset_n |-> ##[1:3] (!cal_done && !data_valid);
    endproperty
    a_hw_quiet: assert property (p_hw_quiet) else $error("output during reset");
    property p_valid_done;
        data_valid |-> cal_done;
    endproperty
    a_valid_done: assert property (p_valid_done) else $error("data before cal");
    property p_follower;
        follower_strap [*3] |-> sync_oe_n;
    endproperty
    a_follower: assert property (p_follower) else $error("follower drives sync");
    property p_master_drive;
        sync_out |-> !sync_oe_n && !follower_strap;
    endproperty
    a_master_drive: assert property (p_master_drive) else $error("sync not driven");
    property p_sync_pulse;
        $rose(sync_out) |-> sync_out [*4] ##1 !sync_out;
    endproperty
    a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse length");
    property p_shutdown;
        ctrl_wr && reg_wdata[2] && reg_wdata[0] |-> ##[1:3] (!ref_en && !core_clk_en);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not entered");
    property p_standby;
        ctrl_wr && reg_wdata[1:0] == 2'h3 && !reg_wdata[2]
            |-> ##[1:3] (ref_en && core_clk_en && !analog_en);
    endproperty
    a_standby: assert property (p_standby) else $error("standby wrong");
    property p_rd_stat;
        s_stat_rd |=> reg_rdata[0] == $past(cal_done);
    endproperty
    a_rd_stat: assert property (p_rd_stat) else $error("status bit wrong");
endmodule

bind adccal_ctrl adccal_ctrl_properties #(.PCAL_CYC(PCAL_CYC)) u_props (
    .sys_clk(sys_clk), .nrst(nrst), .hw_reset_n(hw_reset_n),
    .follower_strap(follower_strap), .sync_out(sync_out), .sync_oe_n(sync_oe_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cal_done(cal_done), .data_valid(data_valid),
    .cal_regs_init(cal_regs_init), .core_clk_en(core_clk_en), .ref_en(ref_en),
    .analog_en(analog_en));

// [verification/adccal_ctrl_tb_top.sv]
// Purpose: Self-checking bench of the calibration control.
// Assumes: Counts shortened; one delay unit is one cycle.
// Notes: Read results are checked from a queue one cycle after each read.
`timescale 1ns/100ps
`include "adccal_defines.svh"

module adccal_ctrl_tb_top
    import adccal_pkg::*;
();
    localparam int PCAL = 64;
    localparam int POR = 16;
    localparam int BG = 256;
    logic sys_clk, nrst, hw_reset_n, follower_strap, sync_in, sync_out, sync_oe_n;
    logic [9:0] reg_addr;
    adccal_byte_t reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, cal_done, data_valid, bg_cal_active, cal_regs_init;
    logic core_clk_en, ref_en, analog_en, fire, peer_sync, group_ok, rd_d, b;
    logic [15:0] exp_q[$];
    logic [31:0] seed;
    int num_errors, tests_run, cycles, sync_cnt, n;

    adccal_ctrl #(.PCAL_CYC(PCAL), .BGCAL_CYC(BG), .POR_WAIT_CYC(POR), .DLY_UNIT_CYC(1)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .hw_reset_n(hw_reset_n),
        .follower_strap(follower_strap), .sync_in(sync_in), .sync_out(sync_out),
        .sync_oe_n(sync_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cal_done(cal_done), .data_valid(data_valid),
        .bg_cal_active(bg_cal_active), .cal_regs_init(cal_regs_init),
        .core_clk_en(core_clk_en), .ref_en(ref_en), .analog_en(analog_en));
    adccal_peer_model peer (.clk(sys_clk), .fire(fire), .dev_cal_done(cal_done),
        .peer_sync(peer_sync), .group_ok(group_ok));
    assign sync_in = sync_oe_n ? peer_sync : sync_out;

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Timeout and the read monitor share the clock edge.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (sync_out && !sync_oe_n)
            sync_cnt++;
        if (rd_d)
        begin
            check(reg_rdata & exp_q[0][15:8], exp_q[0][7:0]);
            void'(exp_q.pop_front());
        end
        rd_d <= reg_rd;
        if (cycles == 8000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic wr(input logic [9:0] a, input adccal_byte_t v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input adccal_byte_t m, input adccal_byte_t e);
        @(posedge sys_clk);
        exp_q.push_back({m, e});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic wait_done(output int k);
        k = 0;
        while (cal_done !== 1'b1 && k < 2000)
        begin
            @(negedge sys_clk);
            k++;
        end
    endtask

    task automatic do_reset(input logic strap);
        @(posedge sys_clk);
        nrst <= 1'b0;
        follower_strap <= strap;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        sync_cnt = 0;
    endtask

    initial
    begin
        nrst = 1'b0;
        hw_reset_n = 1'b1;
        follower_strap = 1'b0;
        reg_addr = 10'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rd_d = 1'b0;
        fire = 1'b0;
        seed = xs(32'd54);
        do_reset(1'b0);
        wait_done(n);
        check(8'(n >= POR + PCAL), 8'h01);
        check(8'(sync_cnt), 8'h04);
        rd(`ADCCAL_ADDR_STAT, 8'h05, 8'h05);
        d = 8'(seed[3:0]);
        wr(`ADCCAL_ADDR_DLY_LO, d);
        wr(`ADCCAL_ADDR_DLY_HI, 8'h00);
        rd(`ADCCAL_ADDR_DLY_LO, 8'hFF, d);
        rd({2'h1, seed[15:8]}, 8'hFF, 8'h00);
        wr(`ADCCAL_ADDR_CTRL, 8'h00);
        repeat (3) @(negedge sys_clk);
        check({cal_done, cal_regs_init, data_valid}, 8'h02);
        wr(`ADCCAL_ADDR_CTRL, 8'h01);
        wait_done(n);
        check(8'(n >= PCAL + d), 8'h01);
        rd(`ADCCAL_ADDR_DLY_LO, 8'hFF, d);
        b = bg_cal_active;
        n = 0;
        while (bg_cal_active === b && n < BG + 10)
        begin
            @(negedge sys_clk);
            n++;
        end
        check({bg_cal_active ^ b, cal_done}, 8'h03);
        wr(`ADCCAL_ADDR_CTRL, 8'h03);
        repeat (3) @(negedge sys_clk);
        check({ref_en, core_clk_en, analog_en, data_valid}, 8'h0C);
        wr(`ADCCAL_ADDR_CTRL, 8'h05);
        repeat (3) @(negedge sys_clk);
        check({ref_en, core_clk_en, analog_en, data_valid}, 8'h00);
        rd(`ADCCAL_ADDR_DLY_LO, 8'hFF, d);
        wr(`ADCCAL_ADDR_CTRL, 8'h00);
        wr(`ADCCAL_ADDR_CTRL, 8'h01);
        wait_done(n);
        @(posedge sys_clk);
        hw_reset_n <= 1'b0;
        wr(`ADCCAL_ADDR_DLY_LO, 8'h0A);
        repeat (3) @(negedge sys_clk);
        check({cal_done, data_valid, ref_en}, 8'h01);
        @(posedge sys_clk);
        hw_reset_n <= 1'b1;
        wait_done(n);
        check(8'(n >= PCAL), 8'h01);
        rd(`ADCCAL_ADDR_DLY_LO, 8'hFF, 8'h00);
        do_reset(1'b1);
        repeat (POR + PCAL + 300) @(negedge sys_clk);
        check({cal_done, sync_oe_n, 6'(sync_cnt)}, 8'h40);
        @(posedge sys_clk);
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        wait_done(n);
        check(8'(n < 2000), 8'h01);
        repeat (100) @(negedge sys_clk);
        check({7'h0, group_ok}, 8'h01);
        rd(`ADCCAL_ADDR_STAT, 8'h05, 8'h01);
        repeat (2) @(posedge sys_clk);
        report_and_stop();
    end
endmodule

// [verification/adccal_peer_model.sv]
// Purpose: Peer master converter and the host's status gate.
// Assumes: Same sample clock as the device.
// Notes: The sync net idles low between pulses, as if pulled down.
`timescale 1ns/100ps
`include "adccal_defines.svh"

module adccal_peer_model
(
    // Clock and trigger
    input wire logic clk,
    input wire logic fire,
    // Device status
    input wire logic dev_cal_done,
    // Peer outputs
    output logic peer_sync,
    output logic group_ok
);
    int pulse_q;
    int cal_q;

    always_ff @(posedge clk)
    begin
        if (fire)
            pulse_q <= `ADCCAL_SYNC_PULSE_CYC;
        else if (pulse_q > 0)
            pulse_q <= pulse_q - 1;
    end
    // The peer takes a different time to calibrate than the device.
    always_ff @(posedge clk)
    begin
        if (fire)
            cal_q <= 90;
        else if (cal_q > 0)
            cal_q <= cal_q - 1;
    end
    assign peer_sync = pulse_q > 0;
    assign group_ok = dev_cal_done && cal_q == 0;
endmodule
